// ==== rtl/arb_defs.svh ====
`ifndef ARB_DEFS_SVH
`define ARB_DEFS_SVH

// request synchroniser depth in flip-flops
`define ARB_SYNC_STAGES 2
// reset values of the grant, float and request outputs, active-low signals idle high
`define ARB_GRANT_N_RST 1'b1
`define ARB_FLOAT_RST   1'b0
`define ARB_REQ_N_RST   1'b1

`endif

// ==== rtl/arb_pkg.sv ====
package arb_pkg;
   typedef enum logic [2:0] {
      ARB_OWN,
      ARB_GRANT,
      ARB_HOLD,
      ARB_RETURN,
      ARB_SETTLE
   } arb_state_e;

   typedef enum logic [1:0] {
      EXT_IDLE,
      EXT_WAIT,
      EXT_OWN
   } ext_state_e;
endpackage

// ==== rtl/arb_link_if.sv ====
`timescale 1ns/1ps
interface arb_link_if;
   logic bus_request_n;
   logic bus_grant_n;
   logic address_strobe_n;
   logic cycle_ack_size_n;
   logic locked_cycle_n;
   logic bus_fault_in_n;

   modport cpu_end (
      input  bus_request_n,
      output bus_grant_n,
      output address_strobe_n,
      input  cycle_ack_size_n,
      output locked_cycle_n,
      input  bus_fault_in_n
   );

   modport ext_end (
      output bus_request_n,
      input  bus_grant_n,
      input  address_strobe_n,
      input  cycle_ack_size_n,
      input  locked_cycle_n,
      output bus_fault_in_n
   );
endinterface

// ==== rtl/cpu_bus_arbiter.sv ====
// Notes on behaviour
// - request may arrive during or between cycles
// - request synchronised within two clocks
// - pending internal cycle starts before grant
// - no grant while locked sequence runs
// - other party aborts lock with bus fault
// - master holds request throughout its ownership
// - master waits for grant and strobe negated
// - master waits acknowledge negated, no other owner
// - processor yields after started cycle completes
// - requests seen during reset, halt, double fault; reset here clears the synchroniser and state
// - idle state: own bus, no grant
// - request: state 1 then state 2
// - request gone: state 3, grant negated
// - state 4 then back to idle
// - state change on edge, grant follows
// - float after strobe and lock negated
// - drive again right after float release
// - wired-or request seen as one
// - requester arbitrates among several masters
// - three-wire peripheral adapted by and gate
`timescale 1ns/1ps
`include "arb_defs.svh"
module cpu_bus_arbiter (
   input  wire logic sys_clk,
   input  wire logic rst,
   arb_link_if.cpu_end link,
   // processor core side
   input  wire logic cycle_pending,
   input  wire logic cycle_locked,
   input  wire logic halted,
   output logic      cycle_started,
   output logic      cycle_busy,
   output logic      bus_float,
   output logic      arb_granted
);
   import arb_pkg::*;

   // -----------------------------------------------------------
   // request synchroniser
   // -----------------------------------------------------------
   logic [`ARB_SYNC_STAGES-1:0] req_sync_ff;
   wire                         req_sync;

   // first stage feeds only the second one
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         req_sync_ff <= '0;
      end else begin
         req_sync_ff <= {req_sync_ff[0], ~link.bus_request_n};
      end
   end
   assign req_sync = req_sync_ff[`ARB_SYNC_STAGES-1];

   // -----------------------------------------------------------
   // processor bus cycle model
   // -----------------------------------------------------------
   logic as_ff;
   logic lock_ff;
   logic strobe_n_ff;
   logic lock_n_ff;
   logic t_ff;
   logic nxt_as;
   logic nxt_lock;
   wire  ack_seen;
   wire  start_cycle;
   wire  may_start;

   assign ack_seen  = ~link.cycle_ack_size_n | ~link.bus_fault_in_n;
   // a decided cycle may start even with a request pending, grant waits for it;
   // once the arbiter leaves idle no new cycle may start behind the grant
   assign may_start = ~t_ff & ~halted;
   assign start_cycle = cycle_pending & ~as_ff & may_start;

   always_comb begin
      nxt_as   = as_ff;
      nxt_lock = lock_ff;
      if (start_cycle) begin
         nxt_as = 1'b1;
         if (cycle_locked) begin
            nxt_lock = 1'b1;
         end
      end else if (as_ff & ack_seen) begin
         nxt_as = 1'b0;
         // fault aborts a locked sequence so the bus can be yielded
         if (~link.bus_fault_in_n | ~cycle_locked) begin
            nxt_lock = 1'b0;
         end
      end else if (~as_ff & (~cycle_locked | ~link.bus_fault_in_n)) begin
         // a fault also ends a lock held between cycles
         nxt_lock = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         as_ff       <= 1'b0;
         lock_ff     <= 1'b0;
         strobe_n_ff <= 1'b1;
         lock_n_ff   <= 1'b1;
      end else begin
         as_ff       <= nxt_as;
         lock_ff     <= nxt_lock;
         strobe_n_ff <= ~nxt_as;
         lock_n_ff   <= ~nxt_lock;
      end
   end

   // -----------------------------------------------------------
   // arbitration state machine
   // -----------------------------------------------------------
   arb_state_e state_ff;
   arb_state_e nxt_state;
   wire        grant_ok;

   // halt does not stop recognition; reset clears the synchroniser and the state
   assign grant_ok = req_sync & ~lock_ff & ~start_cycle;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ARB_OWN: begin
            if (grant_ok) begin
               nxt_state = ARB_GRANT;
            end
         end
         ARB_GRANT: begin
            nxt_state = ARB_HOLD;
         end
         ARB_HOLD: begin
            if (~req_sync) begin
               nxt_state = ARB_RETURN;
            end
         end
         ARB_RETURN: begin
            nxt_state = ARB_SETTLE;
         end
         ARB_SETTLE: begin
            nxt_state = ARB_OWN;
         end
         default: begin
            nxt_state = ARB_OWN;
         end
      endcase
   end

   wire g_next;
   wire t_next;
   assign g_next = (nxt_state == ARB_GRANT) | (nxt_state == ARB_HOLD);
   assign t_next = (nxt_state != ARB_OWN);

   logic grant_n_ff;
   logic bus_float_ff;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_ff <= ARB_OWN;
         t_ff     <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         t_ff     <= t_next;
      end
   end

   // grant pin moves on the falling edge after the state is entered
   always_ff @(negedge sys_clk) begin
      if (rst) begin
         grant_n_ff <= `ARB_GRANT_N_RST;
      end else begin
         grant_n_ff <= ~((state_ff == ARB_GRANT) | (state_ff == ARB_HOLD));
      end
   end

   // float waits for strobe and lock to drop; release is immediate
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         bus_float_ff <= `ARB_FLOAT_RST;
      end else if (~t_next) begin
         bus_float_ff <= 1'b0;
      end else if (t_ff & ~as_ff & ~lock_ff) begin
         bus_float_ff <= 1'b1;
      end
   end

   logic started_ff;
   logic granted_ff;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         started_ff <= 1'b0;
         granted_ff <= 1'b0;
      end else begin
         started_ff <= start_cycle;
         granted_ff <= g_next;
      end
   end

   // -----------------------------------------------------------
   // outputs
   // -----------------------------------------------------------
   // active-low pins come from their own flops, no inverter after the register
   assign link.bus_grant_n      = grant_n_ff;
   assign link.address_strobe_n = strobe_n_ff;
   assign link.locked_cycle_n   = lock_n_ff;
   assign cycle_started         = started_ff;
   assign cycle_busy            = as_ff;
   assign bus_float             = bus_float_ff;
   assign arb_granted           = granted_ff;
endmodule

// ==== rtl/ext_bus_master.sv ====
`timescale 1ns/1ps
`include "arb_defs.svh"
module ext_bus_master (
   input  wire logic sys_clk,
   input  wire logic rst,
   arb_link_if.ext_end link,
   // user side
   input  wire logic want_bus,
   input  wire logic others_own,
   input  wire logic abort_lock,
   output logic      own_bus,
   output logic      waiting
);
   import arb_pkg::*;

   // -----------------------------------------------------------
   // ownership sequence
   // -----------------------------------------------------------
   ext_state_e state_ff;
   ext_state_e nxt_state;
   wire        bus_free;

   // grant asserted, strobe and acknowledge negated, no other owner
   assign bus_free = ~link.bus_grant_n & link.address_strobe_n
                     & link.cycle_ack_size_n & ~others_own;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         EXT_IDLE: begin
            if (want_bus) begin
               nxt_state = EXT_WAIT;
            end
         end
         EXT_WAIT: begin
            if (!want_bus) begin
               nxt_state = EXT_IDLE;
            end else if (bus_free) begin
               nxt_state = EXT_OWN;
            end
         end
         EXT_OWN: begin
            if (!want_bus) begin
               nxt_state = EXT_IDLE;
            end
         end
         default: begin
            nxt_state = EXT_IDLE;
         end
      endcase
   end

   logic req_n_ff;
   logic fault_n_ff;
   logic own_ff;
   logic wait_ff;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_ff   <= EXT_IDLE;
         req_n_ff   <= `ARB_REQ_N_RST;
         fault_n_ff <= 1'b1;
         own_ff     <= 1'b0;
         wait_ff    <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         // request held for the whole ownership, dropped to hand back
         // also stands for a three-wire acknowledge, so no and gate is needed
         req_n_ff   <= (nxt_state == EXT_IDLE);
         // fault only while a lock blocks the grant
         fault_n_ff <= ~(abort_lock & ~link.locked_cycle_n & (nxt_state == EXT_WAIT));
         own_ff     <= (nxt_state == EXT_OWN);
         wait_ff    <= (nxt_state == EXT_WAIT);
      end
   end

   assign link.bus_request_n  = req_n_ff;
   assign link.bus_fault_in_n = fault_n_ff;
   assign own_bus             = own_ff;
   assign waiting             = wait_ff;
endmodule

// ==== dv/arb_link_properties.sv ====
`timescale 1ns/1ps
module arb_link_properties (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic bus_request_n,
   input wire logic bus_grant_n,
   input wire logic address_strobe_n,
   input wire logic cycle_ack_size_n,
   input wire logic locked_cycle_n,
   input wire logic bus_fault_in_n
);
   // ----
   // link checks
   // ----
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // two sync stages and a state edge come before the pin
   AST_GRANT_NOT_EARLY: assert property ($fell(bus_request_n) && bus_grant_n |-> bus_grant_n[*3])
      else $error("grant before request was synchronised");
   AST_GRANT_SOON: assert property ($fell(bus_request_n) && bus_grant_n ##1
      (!bus_request_n && locked_cycle_n && address_strobe_n)[*5] |-> !bus_grant_n)
      else $error("grant late on an idle bus");
   AST_NO_GRANT_LOCKED: assert property (!locked_cycle_n && bus_grant_n |=> bus_grant_n)
      else $error("grant during locked sequence");
   AST_GRANT_HELD: assert property (!bus_request_n && !bus_grant_n |=> !bus_grant_n)
      else $error("grant dropped while request held");
   AST_GRANT_RELEASE: assert property ($rose(bus_request_n) && !bus_grant_n |->
      !bus_grant_n[*3] ##1 bus_grant_n)
      else $error("grant release timing wrong");
   AST_SETTLE_GAP: assert property ($rose(bus_grant_n) |-> bus_grant_n[*3])
      else $error("grant back without passing idle");
   AST_NO_CYCLE_GRANTED: assert property (!bus_grant_n && address_strobe_n |=> address_strobe_n)
      else $error("cycle started after grant");
   AST_ACK_ENDS_CYCLE: assert property (!address_strobe_n && !cycle_ack_size_n |->
      ##[1:2] address_strobe_n)
      else $error("cycle not completed on acknowledge");
   AST_FAULT_ENDS_LOCK: assert property (!bus_fault_in_n && !locked_cycle_n |->
      ##[1:2] locked_cycle_n)
      else $error("bus fault did not end the lock");
   AST_RESET_IDLE: assert property ($fell(rst) |-> bus_grant_n && address_strobe_n &&
      locked_cycle_n && bus_request_n && bus_fault_in_n)
      else $error("link not idle after reset");
   cover property ($fell(bus_grant_n));
   cover property (!locked_cycle_n && !bus_request_n);
   cover property ($fell(bus_fault_in_n));
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/1ps
module tb;
   // ----
   // bench
   // ----
   logic       sys_clk, rst, cycle_pending, cycle_locked, halted, want_bus, others_own;
   logic       abort_lock, cycle_started, cycle_busy, bus_float, arb_granted, own_bus, waiting;
   int         mismatches = 0;
   int         checks_done = 0;
   // halted, others_own, expected own_bus, expected waiting
   logic [3:0] rows [3] = '{4'h2, 4'ha, 4'h5};

   arb_link_if link ();
   cpu_bus_arbiter cpu_bus_arbiter_i (.sys_clk(sys_clk), .rst(rst), .link(link),
      .cycle_pending(cycle_pending), .cycle_locked(cycle_locked), .halted(halted),
      .cycle_started(cycle_started), .cycle_busy(cycle_busy), .bus_float(bus_float),
      .arb_granted(arb_granted));
   ext_bus_master ext_bus_master_i (.sys_clk(sys_clk), .rst(rst), .link(link),
      .want_bus(want_bus), .others_own(others_own), .abort_lock(abort_lock),
      .own_bus(own_bus), .waiting(waiting));
   arb_link_properties arb_link_properties_i (.sys_clk(sys_clk), .rst(rst),
      .bus_request_n(link.bus_request_n), .bus_grant_n(link.bus_grant_n),
      .address_strobe_n(link.address_strobe_n), .cycle_ack_size_n(link.cycle_ack_size_n),
      .locked_cycle_n(link.locked_cycle_n), .bus_fault_in_n(link.bus_fault_in_n));

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // slave answers every strobe half a clock later
   always @(negedge sys_clk) link.cycle_ack_size_n <= link.address_strobe_n;

   function automatic logic sig(input int w);
      case (w)
         0: sig = arb_granted;
         1: sig = bus_float;
         2: sig = own_bus;
         3: sig = cycle_busy;
         default: sig = !link.bus_fault_in_n;
      endcase
   endfunction

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic got, input logic exp, input string m);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask

   task automatic wait_for(input int w, input logic v);
      int n;
      n = 0;
      while (sig(w) !== v && n < 40) begin
         @(negedge sys_clk);
         n++;
      end
      chk(sig(w), v, "wait expired");
      if (sig(w) !== v) tally_and_finish();
   endtask

   initial begin
      {rst, cycle_pending, cycle_locked, halted, want_bus, others_own, abort_lock} = 7'h40;
      repeat (3) @(negedge sys_clk);
      rst = 1'b0;
      chk(link.bus_grant_n, 1'b1, "grant after reset");
      chk(bus_float, 1'b0, "float after reset");
      foreach (rows[i]) begin
         {halted, others_own} = rows[i][3:2];
         want_bus = 1'b1;
         wait_for(1, 1'b1);
         repeat (4) @(negedge sys_clk);
         chk(arb_granted, 1'b1, "grant held");
         chk(own_bus, rows[i][1], "ownership");
         chk(waiting, rows[i][0], "waiting");
         want_bus = 1'b0;
         wait_for(1, 1'b0);
         chk(arb_granted, 1'b0, "grant after release");
         chk(own_bus, 1'b0, "ownership ended");
      end
      {halted, others_own, cycle_pending, want_bus} = 4'h3;
      wait_for(3, 1'b1);
      chk(cycle_started, 1'b1, "start pulse missing");
      cycle_pending = 1'b0;
      wait_for(1, 1'b1);
      chk(cycle_busy, 1'b0, "floated with cycle running");
      wait_for(2, 1'b1);
      want_bus = 1'b0;
      wait_for(1, 1'b0);
      {cycle_locked, cycle_pending} = 2'h3;
      wait_for(3, 1'b1);
      want_bus = 1'b1;
      repeat (10) @(negedge sys_clk);
      chk(arb_granted, 1'b0, "grant during lock");
      abort_lock = 1'b1;
      wait_for(4, 1'b1);
      {cycle_locked, cycle_pending, abort_lock} = 3'h0;
      wait_for(2, 1'b1);
      {rst, want_bus} = 2'h2;
      repeat (3) @(negedge sys_clk);
      rst = 1'b0;
      chk(arb_granted, 1'b0, "grant after second reset");
      chk(bus_float, 1'b0, "float after second reset");
      repeat (2) @(negedge sys_clk);
      tally_and_finish();
   end
endmodule
